// [src/sr_write_protect.v]
// Status register write protection: decides acceptance of status register
// writes and reloads the volatile mode bits on every reset.
// Assumes a Wishbone master drives commands; the write-protect pin is asynchronous.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "sr_protect_consts.vh"

// Function
// - Modes 0,0: write status command accepted when write latch enabled first.
// - Modes 0,0: write-protect pin level plays no part in the decision.
// - Modes 0,1 with pin low: every status write rejected regardless of latch.
// - Modes 0,1 with pin high: write accepted when latch enabled first.
// - Modes 1,0: all status writes blocked until the next reset of any kind.
// - Reset with stored 1,0 loads volatile modes with 0,0.
// - Modes 1,1 unlocked: writes blocked until reset; soft reset loads 0,1.
// - Modes 1,1 locked: writes refused until hardware reset; soft reset keeps 1,1.
// - Soft reset loads volatile modes with the stored values when those are 0,0 or 0,1.
module sr_write_protect
(
  input  wire        clk,        // 200 MHz clock
  input  wire        rst_b,      // Async active-low reset
  input  wire        wp_b,       // Write-protect pin, active low
  input  wire [31:0] wb_adr_i,   // Wishbone address
  input  wire [31:0] wb_dat_i,   // Wishbone write data
  input  wire [3:0]  wb_sel_i,   // Wishbone byte selects
  input  wire        wb_we_i,    // Wishbone write enable
  input  wire        wb_cyc_i,   // Wishbone cycle
  input  wire        wb_stb_i,   // Wishbone strobe
  output reg  [31:0] wb_dat_o,   // Wishbone read data
  output reg         wb_ack_o,   // Wishbone acknowledge
  output reg         wr_cycle_o  // One-cycle pulse: internal write cycle started
);

  // ------------------------------------------------------------
  // Reset release and pin synchroniser
  // ------------------------------------------------------------
  reg [1:0] rst_sync_ff;
  wire      rst_n = rst_sync_ff[1];
  reg [2:0] wp_sync_ff;
  reg       wp_level_ff;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  // Three-stage shift of the asynchronous pin
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wp_sync_ff <= 3'h0;
    else
      wp_sync_ff <= {wp_sync_ff[1:0], wp_b};
  end

  // Pin level changes only once stages two and three agree, so a one-cycle glitch is never seen
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wp_level_ff <= 1'b0;
    else if (wp_sync_ff[1] == wp_sync_ff[2])
      wp_level_ff <= wp_sync_ff[2];
  end

  // ------------------------------------------------------------
  // Protection decision
  // ------------------------------------------------------------
  function is_wrsr_op;
    input [7:0] op;
    begin
      is_wrsr_op = (op == `OP_WRSR1) || (op == `OP_WRSR2) ||
                   (op == `OP_WRSR3) || (op == `OP_WRSR4);
    end
  endfunction

  // Mode pair {hi,lo}, pin level, latch -> write allowed
  function write_allowed;
    input [1:0] mode;
    input       pin_high;
    input       latch;
    begin
      case (mode)
        2'h0:    write_allowed = latch;
        2'h1:    write_allowed = latch & pin_high;
        default: write_allowed = 1'b0;
      endcase
    end
  endfunction

  // Volatile reload value from stored mode pair and lock select
  function [1:0] reload_mode;
    input [1:0] nv_mode;
    input       lock;
    begin
      case (nv_mode)
        2'h2:    reload_mode = 2'h0;
        2'h3:    reload_mode = lock ? 2'h3 : 2'h1;
        default: reload_mode = nv_mode;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  reg [1:0] mode_ff;        // Volatile protect_mode_hi/lo
  reg [1:0] nv_mode_ff;     // Stored protect_mode_hi/lo
  reg       nv_lock_ff;     // Stored permanent_lock_select
  reg       latch_ff;       // write_latch_enabled
  reg [7:0] sr_data_ff;     // Protected status byte
  reg [7:0] last_op_ff;
  reg       refused_ff;     // Last command refused
  reg       soft_rst_ff;    // Software reset in progress

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  // A request already answered is masked so one strobe acts only once
  wire       bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       bus_wr  = bus_req & wb_we_i;
  wire [3:0] ofs     = wb_adr_i[3:0];
  wire       ctrl_wr = bus_wr & (ofs == `OFS_CTRL) & wb_sel_i[0];
  wire       data_wr = bus_wr & (ofs == `OFS_WRDATA) & wb_sel_i[0];
  wire [7:0] op      = wb_dat_i[15:8];
  wire       cmd_go  = ctrl_wr & wb_dat_i[`BIT_WR_CMD] & is_wrsr_op(op);
  wire       allow   = write_allowed(mode_ff, wp_level_ff, latch_ff);
  wire       accept  = cmd_go & allow;

  reg [1:0] nxt_mode;
  reg [1:0] nxt_nv_mode;
  reg       nxt_nv_lock;
  reg       nxt_latch;
  reg [7:0] nxt_sr_data;

  always @*
  begin
    nxt_mode    = mode_ff;
    nxt_nv_mode = nv_mode_ff;
    nxt_nv_lock = nv_lock_ff;
    nxt_latch   = latch_ff;
    nxt_sr_data = sr_data_ff;
    if (soft_rst_ff)
    begin
      nxt_mode  = reload_mode(nv_mode_ff, nv_lock_ff);
      nxt_latch = 1'b0;
    end
    else if (accept)
    begin
      // Accepted write commits both the working and the stored copies
      nxt_sr_data = wb_dat_i[23:16];
      nxt_mode    = {wb_dat_i[24 + `BIT_MODE_HI], wb_dat_i[24 + `BIT_MODE_LO]};
      nxt_nv_mode = nxt_mode;
      nxt_nv_lock = wb_dat_i[24 + `BIT_LOCK_SEL];
      nxt_latch   = 1'b0;
    end
    else if (cmd_go)
      nxt_latch = 1'b0;
    else if (ctrl_wr)
    begin
      if (wb_dat_i[`BIT_LATCH_SET])
        nxt_latch = 1'b1;
      if (wb_dat_i[`BIT_LATCH_CLR])
        nxt_latch = 1'b0;
    end
    // Stored data word may be preloaded to model a power-on image
    if (data_wr && !soft_rst_ff && !accept)
    begin
      nxt_nv_mode = {wb_dat_i[`BIT_MODE_HI], wb_dat_i[`BIT_MODE_LO]};
      nxt_nv_lock = wb_dat_i[`BIT_LOCK_SEL];
    end
  end

  // ------------------------------------------------------------
  // Protection state registers
  // ------------------------------------------------------------
  // Hardware reset clears the stored image too; power-up is modelled as rst_b
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_ff <= `MODE_RST;
    else
      mode_ff <= nxt_mode;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      nv_mode_ff <= `MODE_RST;
    else
      nv_mode_ff <= nxt_nv_mode;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      nv_lock_ff <= 1'b0;
    else
      nv_lock_ff <= nxt_nv_lock;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      latch_ff <= 1'b0;
    else
      latch_ff <= nxt_latch;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sr_data_ff <= `SR_DATA_RST;
    else
      sr_data_ff <= nxt_sr_data;
  end

  // Last opcode and verdict change only for commands with a valid opcode
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      last_op_ff <= 8'h00;
    else if (cmd_go)
      last_op_ff <= op;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      refused_ff <= 1'b0;
    else if (cmd_go)
      refused_ff <= ~allow;
  end

  // Reload is applied one cycle late, so a command in that cycle loses to it
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      soft_rst_ff <= 1'b0;
    else
      soft_rst_ff <= ctrl_wr & wb_dat_i[`BIT_RESET_REQ];
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_cycle_o <= 1'b0;
    else
      wr_cycle_o <= accept;
  end

  // ------------------------------------------------------------
  // Wishbone answer: one cycle after the strobe
  // ------------------------------------------------------------
  reg [31:0] nxt_rdata;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  // Read data is zero outside an answered read, so no stale word lingers
  always @*
  begin
    nxt_rdata = 32'h00000000;
    if (bus_req && !wb_we_i)
    begin
      case (ofs)
        `OFS_CTRL:   nxt_rdata = {16'h0000, last_op_ff, 7'h00, latch_ff};
        `OFS_STATUS: nxt_rdata = {16'h0000, sr_data_ff, 2'h0, refused_ff, allow,
                                  wp_level_ff, 1'b0, mode_ff};
        `OFS_WRDATA: nxt_rdata = {24'h000000, sr_data_ff};
        `OFS_NVM:    nxt_rdata = {29'h00000000, nv_lock_ff, nv_mode_ff};
        default:     nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h00000000;
    else
      wb_dat_o <= nxt_rdata;
  end

endmodule

// [src/sr_protect_consts.vh]
// Constants for the status register write protection block.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef SR_PROTECT_CONSTS_VH
`define SR_PROTECT_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL        4'h0
`define OFS_STATUS      4'h4
`define OFS_WRDATA      4'h8
`define OFS_NVM         4'hC

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_LATCH_SET   0
`define BIT_LATCH_CLR   1
`define BIT_WR_CMD      2
`define BIT_RESET_REQ   3
`define BIT_MODE_LO     0
`define BIT_MODE_HI     1
`define BIT_LOCK_SEL    2

// ------------------------------------------------------------
// Reset values and opcodes
// ------------------------------------------------------------
`define MODE_RST        2'h0
`define SR_DATA_RST     8'h00
`define OP_WRSR1        8'h01
`define OP_WRSR2        8'h31
`define OP_WRSR3        8'h11
`define OP_WRSR4        8'h71

`endif

// [testbench/sr_wp_asserts.sv]
// Port checker for the status register write protection block.
// Bound to sr_write_protect; sees only its ports.
`timescale 1ns/10ps
module sr_wp_asserts
(
  input wire logic        clk,        // Clock
  input wire logic        rst_b,      // Reset
  input wire logic        wp_b,       // Pin
  input wire logic [31:0] wb_adr_i,   // Address
  input wire logic [31:0] wb_dat_i,   // Write data
  input wire logic [3:0]  wb_sel_i,   // Selects
  input wire logic        wb_we_i,    // Direction
  input wire logic        wb_cyc_i,   // Cycle
  input wire logic        wb_stb_i,   // Strobe
  input wire logic [31:0] wb_dat_o,   // Read data
  input wire logic        wb_ack_o,   // Ack
  input wire logic        wr_cycle_o  // Write pulse
);
  logic latch_ff;
  wire  take = wb_cyc_i && wb_stb_i;
  wire  ctrl_wr = take && wb_ack_o && wb_we_i && wb_adr_i[3:0] == 4'h0 && wb_sel_i[0];
  // Shadow of the write latch, kept from acknowledged control writes
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
      latch_ff <= 1'h0;
    else if (ctrl_wr)
      latch_ff <= wb_dat_i[0] & ~|wb_dat_i[3:1];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_ack_answer: assert property (take && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_idle: assert property (!take |=> !wb_ack_o) else $error("ack unasked");
  a_wr_cause: assert property (wr_cycle_o |-> ctrl_wr && wb_dat_i[2])
    else $error("write pulse without command");
  a_wr_opcode: assert property (wr_cycle_o |-> wb_dat_i[15:8] inside
    {8'h01, 8'h31, 8'h11, 8'h71}) else $error("write pulse on bad opcode");
  a_wr_latch: assert property (wr_cycle_o |-> latch_ff)
    else $error("write pulse without latch");
  a_wr_pulse: assert property (wr_cycle_o |=> !wr_cycle_o) else $error("write pulse long");
  a_allow_mode: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:0] == 4'h4
    && wb_dat_o[4] |-> wb_dat_o[1:0] == 2'h0 || (wb_dat_o[1:0] == 2'h1 && wb_dat_o[3]))
    else $error("allow in protected mode");
  cover property (wr_cycle_o && wp_b);
  cover property (wr_cycle_o && !wp_b);
  cover property (take && wb_we_i && wb_dat_i[3]);
endmodule

// [testbench/sr_host.sv]
// Host model: classic Wishbone master issuing register accesses.
// Assumes one clock shared with the block.
`timescale 1ns/10ps
module sr_host
(
  input  wire logic        clk,   // Clock
  input  wire logic        ack,   // Slave ack
  input  wire logic [31:0] rdat,  // Slave data
  output logic      [31:0] adr,   // Address
  output logic      [31:0] wdat,  // Write data
  output logic      [3:0]  sel,   // Selects
  output logic             we,    // Direction
  output logic             cyc,   // Cycle
  output logic             stb    // Strobe
);
  initial {adr, wdat, sel, we, cyc, stb} = '0;
  task xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic ok);
    int i;
    begin
      @(posedge clk);
      {cyc, stb, we, sel} <= {1'h1, 1'h1, w, 4'hF};
      adr <= {28'h0, a};
      wdat <= d;
      ok = 1'h0;
      for (i = 0; i < 16 && !ok; i++)
      begin
        @(posedge clk);
        ok = ack === 1'h1;
      end
      q = rdat;
      {cyc, stb, we} <= 3'h0;
      wdat <= ~d; // Released data must not linger
    end
  endtask
endmodule

// [testbench/testbench.sv]
// Bench for sr_write_protect: register-level command sequences.
// Assumes the host model and the port checker.
`timescale 1ns/10ps
module testbench;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic wp_b = 1'h0;
  wire [31:0] adr, wdat, rdat;
  wire [3:0] sel;
  wire we, cyc, stb, ack, wr_cycle;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_wr = 0;
  int i;
  logic [31:0] q;
  logic [7:0] sb = 8'h00;
  logic [1:0] md = 2'h0;
  logic [2:0] pl [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  logic [1:0] ex [5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h3};
  logic [7:0] ops [4] = '{8'h01, 8'h31, 8'h11, 8'h71};
  always #2.5 clk = ~clk;
  always @(posedge clk) if (wr_cycle === 1'h1) n_wr <= n_wr + 1;
  sr_write_protect dut (.clk(clk), .rst_b(rst_b), .wp_b(wp_b), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wr_cycle_o(wr_cycle));
  sr_host host (.clk(clk), .ack(ack), .rdat(rdat), .adr(adr), .wdat(wdat), .sel(sel),
    .we(we), .cyc(cyc), .stb(stb));
  task final_report;
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ok;
    host.xfer(w, a, d, q, ok);
    if (!ok)
    begin
      n_mismatch++;
      final_report;
    end
  endtask
  // Optional latch set, then a status write command; refusal must leave status byte and modes unchanged and give no write pulse
  task try(input [7:0] op, input [7:0] d, input [2:0] m, input logic l, input logic e);
    int n0;
    n0 = n_wr;
    acc(1'h1, 4'h0, {31'h0, l});
    acc(1'h1, 4'h0, {5'h0, m, d, op, 8'h04});
    if (e) {md, sb} = {m[1:0], d};
    acc(1'h0, 4'h4, 32'h0);
    check(q & 32'hFF03, {16'h0, sb, 6'h0, md});
    check(n_wr - n0, {31'h0, e});
  endtask
  task sreset(input logic [1:0] e);
    acc(1'h1, 4'h0, 32'h8);
    md = e;
    acc(1'h0, 4'h4, 32'h0);
    check(q & 32'h3, {30'h0, e});
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    acc(1'h0, 4'h2, 32'h0);
    check(q, 32'h0);
    for (i = 0; i < 4; i++) try(ops[i], 8'hA0 + i, 3'h0, 1'h1, 1'h1);
    try(8'h01, 8'h55, 3'h0, 1'h0, 1'h0);
    try(8'h02, 8'h56, 3'h0, 1'h1, 1'h0);
    try(8'h31, 8'h11, 3'h1, 1'h1, 1'h1);
    try(8'h11, 8'h22, 3'h0, 1'h1, 1'h0);
    wp_b <= 1'h1;
    repeat (6) @(posedge clk);
    try(8'h71, 8'h33, 3'h2, 1'h1, 1'h1);
    try(8'h01, 8'h44, 3'h0, 1'h1, 1'h0);
    sreset(2'h0);
    try(8'h01, 8'h45, 3'h3, 1'h1, 1'h1);
    try(8'h11, 8'h46, 3'h0, 1'h1, 1'h0);
    sreset(2'h1);
    try(8'h31, 8'h47, 3'h7, 1'h1, 1'h1);
    try(8'h71, 8'h48, 3'h0, 1'h1, 1'h0);
    sreset(2'h3);
    for (i = 0; i < 5; i++)
    begin
      acc(1'h1, 4'h8, {29'h0, pl[i]});
      sreset(ex[i]);
    end
    final_report;
  end
endmodule
bind sr_write_protect sr_wp_asserts chk (.clk(clk), .rst_b(rst_b), .wp_b(wp_b),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wr_cycle_o(wr_cycle_o));
